// *** src/ssasi_defines.vh ***
// Purpose: constants for the serial register and sram access block
// Assumes: ref_clk 100 MHz samples the serial clock as a plain input
// Notes on behaviour
// - register access: command bit7 one, bit6 write, six-bit address, data byte
// - frame buffer access violation raises the frame underrun event
// - one buffer for rx and tx; new frames overwrite stored payload
// - frame buffer at 00..7F, cipher space at 82..94
// - sram read data leaves on miso from the third byte
// - sram write stores mosi bytes from the third byte
// - address counter increments per byte until chip select rises
// - sram mode accesses never raise frame underrun
// - after rx start, sram read may fetch the length header safely
// - first miso byte of every transfer is the status echo
// - control bits 3:2 choose echo: zero, state, strength, irq flags
// - control register 04 read/write with reset value 22
// - four read-only identification bytes
// - register 1C returns fixed part code; writes ignored
// - register 1D returns revision code; writes ignored
`ifndef SSASI_DEFINES_VH
`define SSASI_DEFINES_VH
`define SSASI_REG_CTRL      6'h04
`define SSASI_REG_PART      6'h1C
`define SSASI_REG_REV       6'h1D
`define SSASI_REG_MAN0      6'h1E
`define SSASI_REG_MAN1      6'h1F
`define SSASI_CTRL_RESET    8'h22
`define SSASI_ECHO_HI       3
`define SSASI_ECHO_LO       2
`define SSASI_CMD_SRAM_RD   3'h0
`define SSASI_CMD_SRAM_WR   3'h2
`define SSASI_CMD_FB_RD     3'h1
`define SSASI_CMD_FB_WR     3'h3
`define SSASI_FB_LAST       8'h7F
`define SSASI_AES_FIRST     8'h82
`define SSASI_AES_LAST      8'h94
`define SSASI_FIFO_DEPTH    8
`endif

// *** src/ssasi_fifo.v ***
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty derive from pointers with one extra wrap bit
`timescale 1ns/1ps
module ssasi_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wp_r;
    reg [AW:0]      rp_r;
    wire            empty = (wp_r == rp_r);
    wire            full  = (wp_r[AW] != rp_r[AW]) &&
                            (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp_r[AW-1:0]];
    always @(posedge clk) begin
        if (rst) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wp_r[AW-1:0]] <= in_data;
                wp_r <= wp_r + 1'b1;
            end
            if (out_ready && !empty)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule

// *** src/ssasi_top.v ***
// Purpose: slave serial access: registers, sram space, status echo, id bytes
// Assumes: spi mode 0, msb first; pins pass three sampling flops
// Notes: sram writes queue through a fifo so the write port can stall
`timescale 1ns/1ps
`include "ssasi_defines.vh"
module ssasi_top #(
    parameter [7:0] PART_CODE = 8'h5A,   // arbitrary value
    parameter [7:0] REV_CODE  = 8'h07,   // arbitrary value
    parameter [7:0] MAN0_CODE = 8'h3C,   // arbitrary value
    parameter [7:0] MAN1_CODE = 8'h00    // arbitrary value
) (
    // clock and reset
    input  wire       REF_CLK,
    input  wire       SYS_RST,
    // serial pins
    input  wire       SEL_N,
    input  wire       SCLK,
    input  wire       MOSI,
    output wire       MISO,
    output wire       MISO_OE,
    // transceiver state for the echo byte
    input  wire [7:0] TRX_STATE,
    input  wire [7:0] SIG_STRENGTH,
    input  wire [7:0] IRQ_FLAGS,
    // frame buffer side (sram mode reads this address)
    output wire [7:0] RD_ADDR,
    input  wire [7:0] RD_DATA,
    // frame buffer write stream
    output wire       WR_VALID,
    input  wire       WR_READY,
    output wire [7:0] WR_ADDR,
    output wire [7:0] WR_DATA,
    // events and control bits
    output reg        FRAME_UNDERRUN,
    output wire       FB_MODE_ACTIVE,
    output wire       EXT_AMP_EN,
    output wire       RX_TS_EN,
    output wire       AUTO_FCS,
    output wire       RX_BUF_IND_CTRL,
    output wire       IRQ_MASK_SHOW,
    output wire       IRQ_POL
);
    localparam [3:0] ST_CMD  = 4'h1;
    localparam [3:0] ST_REG  = 4'h2;
    localparam [3:0] ST_ADDR = 4'h4;
    localparam [3:0] ST_DATA = 4'h8;

    function in_map;
        input [7:0] a;
        begin
            in_map = (a <= `SSASI_FB_LAST) ||
                     (a >= `SSASI_AES_FIRST && a <= `SSASI_AES_LAST);
        end
    endfunction

    // three-flop sampling; stage one only feeds stage two
    reg [2:0] sel_s_r;
    reg [2:0] sck_s_r;
    reg [2:0] mosi_s_r;
    reg       sel_n_r;
    reg       sck_r;
    reg       mosi_r;
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sel_s_r  <= 3'h7;
            sck_s_r  <= 3'h0;
            mosi_s_r <= 3'h0;
            sel_n_r  <= 1'b1;
            sck_r    <= 1'b0;
            mosi_r   <= 1'b0;
        end else begin
            sel_s_r  <= {sel_s_r[1:0], SEL_N};
            sck_s_r  <= {sck_s_r[1:0], SCLK};
            mosi_s_r <= {mosi_s_r[1:0], MOSI};
            if (sel_s_r[1] == sel_s_r[2])
                sel_n_r <= sel_s_r[2];
            if (sck_s_r[1] == sck_s_r[2])
                sck_r <= sck_s_r[2];
            if (mosi_s_r[1] == mosi_s_r[2])
                mosi_r <= mosi_s_r[2];
        end
    end
    wire sck_rise = (sck_s_r[1] == sck_s_r[2]) && sck_s_r[2] && !sck_r;
    wire sck_fall = (sck_s_r[1] == sck_s_r[2]) && !sck_s_r[2] && sck_r;
    wire active   = !sel_n_r;

    reg [3:0] state_r;
    reg [2:0] bit_r;
    reg [7:0] sh_in_r;
    reg [7:0] sh_out_r;
    reg [7:0] cmd_r;
    reg [7:0] addr_r;
    reg [7:0] ctrl_r;
    reg       fb_r;
    reg       oe_r;
    reg [3:0] state_nxt;

    wire [7:0] rx_byte = {sh_in_r[6:0], mosi_r};
    wire       byte_end = sck_rise && (bit_r == 3'h7);
    wire [2:0] cmd_top  = rx_byte[7:5];

    reg [7:0] echo;
    always @* begin
        case (ctrl_r[`SSASI_ECHO_HI:`SSASI_ECHO_LO])
            2'h1:    echo = TRX_STATE;
            2'h2:    echo = SIG_STRENGTH;
            2'h3:    echo = IRQ_FLAGS;
            default: echo = 8'h00;
        endcase
    end

    reg [7:0] reg_rd;
    always @* begin
        case (cmd_r[5:0])
            `SSASI_REG_CTRL: reg_rd = ctrl_r;
            `SSASI_REG_PART: reg_rd = PART_CODE;
            `SSASI_REG_REV:  reg_rd = REV_CODE;
            `SSASI_REG_MAN0: reg_rd = MAN0_CODE;
            `SSASI_REG_MAN1: reg_rd = MAN1_CODE;
            default:         reg_rd = 8'h00;
        endcase
    end

    // byte sequencing
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_CMD: begin
                if (byte_end) begin
                    if (rx_byte[7])
                        state_nxt = ST_REG;
                    else if (cmd_top == `SSASI_CMD_SRAM_RD ||
                             cmd_top == `SSASI_CMD_SRAM_WR)
                        state_nxt = ST_ADDR;
                    else
                        state_nxt = ST_DATA;
                end
            end
            ST_REG:  state_nxt = ST_REG;
            ST_ADDR: if (byte_end) state_nxt = ST_DATA;
            ST_DATA: state_nxt = ST_DATA;
            default: state_nxt = ST_CMD;
        endcase
    end

    wire sram_cmd = (cmd_r[7:5] == `SSASI_CMD_SRAM_RD) ||
                    (cmd_r[7:5] == `SSASI_CMD_SRAM_WR);
    wire sram_wr  = cmd_r[7:5] == `SSASI_CMD_SRAM_WR;
    wire fb_wr    = cmd_r[7:5] == `SSASI_CMD_FB_WR;
    wire in_ready;
    wire push     = (state_r == ST_DATA) && byte_end && !cmd_r[7] &&
                    (sram_wr || fb_wr);
    wire push_ok  = push && in_map(addr_r);
    // register reads load the mux once the command byte is in
    wire reg_load = (state_r == ST_REG) && (bit_r == 3'h0) && !cmd_r[6];

    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_r  <= ST_CMD;
            bit_r    <= 3'h0;
            sh_in_r  <= 8'h00;
            sh_out_r <= 8'h00;
            cmd_r    <= 8'h00;
            addr_r   <= 8'h00;
            ctrl_r   <= `SSASI_CTRL_RESET;
            fb_r     <= 1'b0;
            oe_r     <= 1'b0;
            FRAME_UNDERRUN <= 1'b0;
        end else if (!active) begin
            state_r  <= ST_CMD;
            bit_r    <= 3'h0;
            sh_out_r <= echo;
            oe_r     <= 1'b0;
            fb_r     <= 1'b0;
            FRAME_UNDERRUN <= 1'b0;
        end else begin
            oe_r <= 1'b1;
            FRAME_UNDERRUN <= 1'b0;
            state_r <= state_nxt;
            if (sck_rise) begin
                sh_in_r <= rx_byte;
                bit_r   <= bit_r + 3'h1;
            end
            if (sck_fall && bit_r != 3'h0)
                sh_out_r <= {sh_out_r[6:0], 1'b0};
            if (byte_end) begin
                case (state_r)
                    ST_CMD: begin
                        cmd_r <= rx_byte;
                        if (rx_byte[7]) begin
                            sh_out_r <= 8'h00;
                        end else begin
                            addr_r <= 8'h00;
                            fb_r <= !(cmd_top == `SSASI_CMD_SRAM_RD ||
                                      cmd_top == `SSASI_CMD_SRAM_WR);
                            // frame read returns data from byte two on
                            sh_out_r <= RD_DATA;
                        end
                    end
                    ST_REG: begin
                        if (cmd_r[6] && cmd_r[5:0] == `SSASI_REG_CTRL)
                            ctrl_r <= rx_byte;
                        sh_out_r <= 8'h00;
                    end
                    ST_ADDR: begin
                        addr_r   <= rx_byte;
                        // first read byte comes from the start address
                        sh_out_r <= sram_wr ? 8'h00 : RD_DATA;
                    end
                    default: begin
                        addr_r <= addr_r + 8'h01;
                        sh_out_r <= sram_wr ? 8'h00 : RD_DATA;
                        if (!sram_cmd &&
                            (!in_map(addr_r) || (push && !in_ready)))
                            FRAME_UNDERRUN <= 1'b1;
                    end
                endcase
            end
            if (state_r == ST_CMD && bit_r == 3'h0 && !sck_rise)
                sh_out_r <= echo;
            // whole read byte must sit in the shifter, not only bit 7
            if (reg_load)
                sh_out_r <= reg_rd;
        end
    end
    reg  [7:0] reg_hold_r;
    always @(posedge REF_CLK) begin
        if (SYS_RST)
            reg_hold_r <= 8'h00;
        else
            reg_hold_r <= reg_rd;
    end

    // sram reads are plain fetches, no buffer state is touched
    // data bytes preload the next address; the counter moves at byte end
    assign RD_ADDR = (sram_cmd && state_r == ST_ADDR) ? rx_byte :
                     (state_r == ST_DATA) ? addr_r + 8'h01 : 8'h00;
    assign MISO    = reg_load ? reg_hold_r[7] : sh_out_r[7];
    assign MISO_OE = oe_r;
    assign FB_MODE_ACTIVE = fb_r;

    // stored bytes queue to the buffer
    // same buffer for rx and tx writes
    ssasi_fifo #(
        .WIDTH (16),
        .DEPTH (`SSASI_FIFO_DEPTH),
        .AW    (3)
    ) u_wr_fifo (
        .clk       (REF_CLK),
        .rst       (SYS_RST),
        .in_valid  (push_ok),
        .in_ready  (in_ready),
        .in_data   ({addr_r, rx_byte}),
        .out_valid (WR_VALID),
        .out_ready (WR_READY),
        .out_data  ({WR_ADDR, WR_DATA})
    );

    assign EXT_AMP_EN      = ctrl_r[7];
    assign RX_TS_EN        = ctrl_r[6];
    assign AUTO_FCS        = ctrl_r[5];
    assign RX_BUF_IND_CTRL = ctrl_r[4];
    assign IRQ_MASK_SHOW   = ctrl_r[1];
    assign IRQ_POL         = ctrl_r[0];
endmodule

// *** testbench/ssasi_top_assertions.sv ***
// Purpose: port checks for the serial access block
// Assumes: pins reach the core through a few sampling flops
// Notes: select windows span eight cycles to cover that latency
`timescale 1ns/1ps
module ssasi_checker (
    // clock and reset
    input wire       REF_CLK,
    input wire       SYS_RST,
    // serial side
    input wire       SEL_N,
    input wire       MISO_OE,
    // write stream
    input wire       WR_VALID,
    input wire       WR_READY,
    input wire [7:0] WR_ADDR,
    input wire [7:0] WR_DATA,
    // events and control
    input wire       FRAME_UNDERRUN,
    input wire       FB_MODE_ACTIVE,
    input wire       EXT_AMP_EN,
    input wire       RX_TS_EN,
    input wire       AUTO_FCS,
    input wire       RX_BUF_IND_CTRL,
    input wire       IRQ_MASK_SHOW,
    input wire       IRQ_POL
);
    wire [5:0] ctl = {EXT_AMP_EN, RX_TS_EN, AUTO_FCS, RX_BUF_IND_CTRL,
                      IRQ_MASK_SHOW, IRQ_POL};
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    a_oe_idle_low: assert property (SEL_N [*8] |-> !MISO_OE)
        else $error("miso enable while deselected");
    a_oe_sel_high: assert property (!SEL_N [*8] |-> MISO_OE)
        else $error("miso enable low while selected");
    a_ur_one_pulse: assert property (FRAME_UNDERRUN |=> !FRAME_UNDERRUN)
        else $error("underrun longer than one cycle");
    a_ur_not_sram: assert property (FRAME_UNDERRUN |->
        FB_MODE_ACTIVE || $past(FB_MODE_ACTIVE)) else $error("sram underrun");
    a_wr_hold: assert property (WR_VALID && !WR_READY |=>
        WR_VALID && $stable({WR_ADDR, WR_DATA})) else $error("write dropped");
    a_wr_in_map: assert property (WR_VALID |-> WR_ADDR <= 8'h7F ||
        (WR_ADDR >= 8'h82 && WR_ADDR <= 8'h94)) else $error("write off map");
    a_ctrl_reset: assert property ($fell(SYS_RST) |-> ctl == 6'h0A)
        else $error("control bits wrong after reset");
    a_ctrl_sel_only: assert property ($changed(ctl) |-> MISO_OE)
        else $error("control changed while idle");
    c_stall: cover property (WR_VALID && !WR_READY);
    c_ctrl: cover property ($changed(ctl));
    c_sel: cover property (!SEL_N [*8]);
endmodule
bind ssasi_top ssasi_checker chk_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .SEL_N(SEL_N), .MISO_OE(MISO_OE), .WR_VALID(WR_VALID),
    .WR_READY(WR_READY), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
    .FRAME_UNDERRUN(FRAME_UNDERRUN), .FB_MODE_ACTIVE(FB_MODE_ACTIVE),
    .EXT_AMP_EN(EXT_AMP_EN), .RX_TS_EN(RX_TS_EN), .AUTO_FCS(AUTO_FCS),
    .RX_BUF_IND_CTRL(RX_BUF_IND_CTRL), .IRQ_MASK_SHOW(IRQ_MASK_SHOW),
    .IRQ_POL(IRQ_POL));

// *** testbench/ssasi_master.sv ***
// Purpose: serial master model, mode 0, msb first
// Assumes: half period 80 ns, calls start on a clock edge
// Notes: mosi flips when released so stale bits never look valid
`timescale 1ns/1ps
module ssasi_master (
    // serial pins
    output reg  sel_n,
    output reg  sclk,
    output reg  mosi,
    input  wire miso
);
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task start;
        begin
            sel_n = 1'b0;
            #160;
        end
    endtask
    task stop;
        begin
            #80;
            sel_n = 1'b1;
            mosi = ~mosi;
            #240;
        end
    endtask
    task shift(input integer n, input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            for (i = 7; i > 7 - n; i = i - 1) begin
                mosi = tx[i];
                #80;
                sclk = 1'b1;
                rx[i] = miso;
                #80;
                sclk = 1'b0;
            end
        end
    endtask
endmodule

// *** testbench/ssasi_top_tb.sv ***
// Purpose: self-checking bench for the serial access block
// Assumes: the buffer memory is modelled here, answering at once
// Notes: write notes queue up and are checked as the stream drains
`timescale 1ns/1ps
module ssasi_top_tb;
    localparam [31:0] IDS = 32'h196B3EA5; // arbitrary values
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        wr_ready = 1'b0;
    reg [7:0]  trx, sig, irqf, rx, v, e;
    reg [7:0]  mem [0:255];
    reg [7:0]  sh [0:255];
    reg [15:0] nt;
    reg [31:0] seed = 32'h1A619EB0;
    reg [15:0] ewq [$];
    integer    miscompares = 0;
    integer    n_checks = 0;
    integer    i, k;
    wire       sel_n, sclk, mosi, miso, wr_valid;
    wire [7:0] rd_addr, wr_addr, wr_data;
    wire [5:0] ctl;
    always #5 clk = ~clk;
    ssasi_master m (.sel_n(sel_n), .sclk(sclk), .mosi(mosi), .miso(miso));
    ssasi_top #(.PART_CODE(IDS[7:0]), .REV_CODE(IDS[15:8]),
        .MAN0_CODE(IDS[23:16]), .MAN1_CODE(IDS[31:24])) uut (
        .REF_CLK(clk), .SYS_RST(rst), .SEL_N(sel_n), .SCLK(sclk),
        .MOSI(mosi), .MISO(miso), .MISO_OE(), .TRX_STATE(trx),
        .SIG_STRENGTH(sig), .IRQ_FLAGS(irqf), .RD_ADDR(rd_addr),
        .RD_DATA(mem[rd_addr]), .WR_VALID(wr_valid), .WR_READY(wr_ready),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .FRAME_UNDERRUN(),
        .FB_MODE_ACTIVE(), .EXT_AMP_EN(ctl[5]), .RX_TS_EN(ctl[4]),
        .AUTO_FCS(ctl[3]), .RX_BUF_IND_CTRL(ctl[2]),
        .IRQ_MASK_SHOW(ctl[1]), .IRQ_POL(ctl[0]));
    function [7:0] rnd;
        input dummy;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed[7:0];
        end
    endfunction
    task chk(input [63:0] nm, input [7:0] ex, input [7:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== ex) begin
                miscompares = miscompares + 1;
                $display("unexpected %0s: expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task test_done;
        begin
            if (miscompares == 0 && n_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task reg_acc(input [7:0] cmd, input [7:0] d, output [7:0] ec);
        begin
            m.start;
            m.shift(8, cmd, ec);
            m.shift(8, d, v);
            m.stop;
        end
    endtask
    // write three bytes, let them drain, then read them back
    task sram_acc(input [7:0] a);
        begin
            m.start;
            m.shift(8, 8'h40, rx);
            chk("echo", irqf, rx);
            m.shift(8, a, rx);
            for (k = 0; k < 3; k = k + 1) begin
                e = rnd(0);
                sh[a + k] = e;
                ewq.push_back({a + k[7:0], e});
                m.shift(8, e, rx);
            end
            m.stop;
            for (k = 0; k < 2000 && ewq.size() > 0; k = k + 1)
                @(negedge clk);
            chk("drain", 8'h00, ewq.size());
            m.start;
            m.shift(8, 8'h00, rx);
            m.shift(8, a, rx);
            for (k = 0; k < 3; k = k + 1) begin
                m.shift(8, rnd(0), rx);
                chk("sram_rd", sh[a + k], rx);
            end
            m.stop;
        end
    endtask
    // random stalls on the write stream
    always @(negedge clk) wr_ready <= rnd(0) > 8'h50;
    always @(posedge clk) begin
        if (!rst && wr_valid && wr_ready) begin
            nt = ewq.pop_front();
            chk("wr_addr", nt[15:8], wr_addr);
            chk("wr_data", nt[7:0], wr_data);
            mem[wr_addr] <= wr_data;
        end
    end
    initial begin
        #500000;
        miscompares = miscompares + 1;
        test_done;
    end
    initial begin
        trx = rnd(0);
        sig = rnd(0);
        irqf = rnd(0);
        for (i = 0; i < 256; i = i + 1)
            mem[i] = rnd(0);
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (6) @(negedge clk);
        reg_acc(8'h84, 8'h00, rx);
        chk("echo", 8'h00, rx);
        chk("ctrl", 8'h22, v);
        for (i = 0; i < 4; i = i + 1) begin
            e = rnd(0);
            e[3:2] = i;
            reg_acc(8'hC4, e, rx);
            reg_acc(8'h84, rnd(0), rx);
            chk("ctrl", e, v);
            chk("ctl_pin", {e[7:4], e[1:0]}, ctl);
            chk("echo", i == 0 ? 8'h00 : i == 1 ? trx :
                i == 2 ? sig : irqf, rx);
        end
        for (i = 0; i < 4; i = i + 1) begin
            reg_acc(8'hDC + i, ~IDS[8*i +: 8], rx);
            reg_acc(8'h9C + i, rnd(0), rx);
            chk("ident", IDS[8*i +: 8], v);
        end
        m.start;
        m.shift(8, 8'hC4, rx);
        m.shift(5, 8'h00, rx);
        m.stop;
        reg_acc(8'h84, 8'h00, rx);
        chk("echo", irqf, rx);
        chk("ctrl", e, v);
        sram_acc(8'h7D);
        sram_acc(8'h92);
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        chk("ctl_pin", 8'h0A, ctl);
        test_done;
    end
endmodule
